// ### verilog/ssc_pkg.sv
package ssc_pkg;
    // printed offsets are register indices; byte address is four times the index
    localparam logic [11:0] IDX_CTRL_PRIMARY = 12'h028;
    localparam logic [11:0] IDX_CTRL_BUFFER = 12'h029;
    localparam logic [11:0] IDX_STATUS = 12'h029;
    localparam logic [11:0] IDX_BUF_BASE = 12'hf90;
    localparam logic [15:0] ADDR_CTRL_PRIMARY = {2'b00, IDX_CTRL_PRIMARY, 2'b00};
    localparam logic [15:0] ADDR_CTRL_BUFFER = {2'b00, IDX_CTRL_BUFFER, 2'b00};
    localparam logic [15:0] ADDR_STATUS = {2'b00, IDX_STATUS, 2'b00};
    localparam logic [15:0] ADDR_BUF_BASE = {2'b00, IDX_BUF_BASE, 2'b00};
    localparam int unsigned BUF_WORDS = 8;

    localparam int unsigned STAT_ACTIVE_BIT = 7;
    localparam int unsigned STAT_SHIFT_BIT = 6;

    localparam logic [2:0] MODE_TX8 = 3'h0;
    localparam logic [2:0] MODE_TX4 = 3'h2;
    localparam logic [2:0] MODE_TXRX8 = 3'h4;
    localparam logic [2:0] MODE_RX8 = 3'h5;
    localparam logic [2:0] MODE_RX4 = 3'h6;

    localparam logic [2:0] CLK_SEL_SLOW = 3'h0;
    localparam logic [2:0] CLK_SEL_RSVD = 3'h6;
    localparam logic [2:0] CLK_SEL_EXT = 3'h7;
    localparam logic [3:0] LF_EXP = 4'd5;
    localparam logic [3:0] HF_EXP_SLOW = 4'd13;
    localparam logic [3:0] HF_EXP_FAST = 4'd9;

    localparam logic [7:0] PRIMARY_RST = 8'h00;
    localparam logic [4:0] BUFCTL_RST = 5'h00;
    localparam logic [7:0] SO_IDLE = 8'h01;

    // bit layout matches the primary control register
    typedef struct packed {
        logic run;
        logic abort;
        logic [2:0] mode;
        logic [2:0] clk_sel;
    } ssc_ctrl_t;

    typedef struct packed {
        logic [1:0] gap;
        logic [2:0] wcnt;
    } ssc_bufctl_t;

    typedef struct packed {
        logic use_lf;
        logic [3:0] exp;
    } ssc_clk_t;

    typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_GAP} ssc_state_t;
endpackage : ssc_pkg

// ### verilog/ssc_tick_gen.sv
// half-period tick source for the internal shift clock
module ssc_tick_gen import ssc_pkg::*; #(
    parameter int unsigned CNT_W = 14
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    // control
    input wire logic run,
    input wire ssc_clk_t sel,
    input wire logic lf_tick,
    // tick out
    output logic tick
);
    logic [CNT_W-1:0] cnt_r, cnt_nxt, half_last;
    logic evt;

    always_comb begin
        evt = sel.use_lf ? lf_tick : 1'b1;
        // divisor 2^exp means a half period of 2^(exp-1) source events
        half_last = CNT_W'((CNT_W+1)'(1) << (sel.exp - 4'd1)) - CNT_W'(1);
        tick = run && evt && (cnt_r == half_last);
        cnt_nxt = cnt_r;
        if (!run || tick) begin
            cnt_nxt = '0;
        end else if (evt) begin
            cnt_nxt = cnt_r + CNT_W'(1);
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_r <= '0;
        end else if (ce) begin
            cnt_r <= cnt_nxt;
        end
    end
endmodule // ssc_tick_gen

// ### verilog/ssc_serial_port.sv
//Contract
// [R01] run bit clear stops transfer; set starts it.
// [R02] abort bit aborts transfer and clears itself; zero means continue.
// [R03] mode codes: 000 tx8, 010 tx4, 100 txrx8, 101 rx8, 110 rx4.
// [R04] clock codes 000-101 internal dividers, 110 reserved, 111 external pin.
// [R05] in sleep only clock codes 000 and 111 are usable.
// [R06] software changes mode or clock with run 0 and abort 1.
// [R07] both control registers are write-only; no read-modify-write.
// [R08] primary control register resets to all zeros.
// [R09] buffer control low five bits reset to zero.
// [R10] frame gap codes give frame time 1, 2, 4, 8 word times.
// [R11] software programs frame gap 00 outside tx/rx 8-bit mode.
// [R12] word count codes 000-111 select 1 to 8 buffer words.
// [R13] 4-bit transfers use low nibble; received upper nibble is zero.
// [R14] transmit and receive walk the buffer upward from its base.
// [R15] word count setting is kept after a burst completes.
// [R16] software writes buffer control only while port is stopped.
// [R17] status bit 7 shows transfer in progress.
// [R18] status bit 6 shows shift in progress.
// [R19] run cleared ends at word end; abort ends at once.
// [R20] transmit bit changes on falling clock, receive samples on rising.
// [R21] words shift least significant bit first.
// [R22] done pulse after the selected number of words.
// [R23] read at index 29h gives status; write sets buffer control.
// [R24] reserved mode or clock codes act as a stopped port.
module ssc_serial_port import ssc_pkg::*; #(
    parameter int unsigned DIV_W = 14
) (
    // clock, reset, enable
    input wire logic CLK,
    input wire logic NRST,
    input wire logic CE,
    // apb slave
    input wire logic [15:0] PADDR,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // system clocking state
    input wire logic PRESCALER_TAP_SEL,
    input wire logic PRESCALER_BASE_SEL,
    input wire logic SLEEP_MODE,
    input wire logic LF_TICK,
    // serial pins
    input wire logic SERIAL_CLOCK_PIN_I,
    output logic SERIAL_CLOCK_PIN_O,
    output logic SERIAL_CLOCK_PIN_OE,
    output logic SERIAL_OUT_PIN,
    input wire logic SERIAL_IN_PIN,
    // completion
    output logic SERIAL_DONE_IRQ
);
    ssc_ctrl_t ctrl_r, ctrl_nxt;
    ssc_bufctl_t bctl_r, bctl_nxt;
    ssc_state_t state_r, state_nxt;
    ssc_clk_t clk_cfg;
    logic [7:0] data_buffer_ram [BUF_WORDS];
    logic [7:0] shreg_r, shreg_nxt, shifted, rx_word, so_r, so_nxt;
    logic [3:0] bitcnt_r, bitcnt_nxt, last_bit;
    logic [2:0] widx_r, widx_nxt, nidx, gap_mul;
    logic [6:0] gapcnt_r, gapcnt_nxt, gap_len;
    logic sck_r, sck_nxt, oe_r, oe_nxt, irq_r, irq_nxt, pin_q;
    logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic acc, wr_fire, a_prim, a_bctl, a_buf, wr_prim, wr_bctl;
    logic tx_mode, rx_mode, four, mode_ok, clk_ok, cfg_ok, ext;
    logic tick, fall_evt, rise_evt, word_done, start;
    logic buf_we;
    logic [2:0] buf_wa;
    logic [7:0] buf_wd;

    // mode and clock decode
    always_comb begin
        ext = (ctrl_r.clk_sel == CLK_SEL_EXT);
        four = (ctrl_r.mode == MODE_TX4) || (ctrl_r.mode == MODE_RX4); // [R03]
        tx_mode = (ctrl_r.mode == MODE_TX8) || (ctrl_r.mode == MODE_TX4)
            || (ctrl_r.mode == MODE_TXRX8);
        rx_mode = (ctrl_r.mode == MODE_TXRX8) || (ctrl_r.mode == MODE_RX8)
            || (ctrl_r.mode == MODE_RX4);
        mode_ok = tx_mode || rx_mode;
        clk_ok = (ctrl_r.clk_sel != CLK_SEL_RSVD) && (!SLEEP_MODE || ext
            || (ctrl_r.clk_sel == CLK_SEL_SLOW)); // [R04] [R05]
        cfg_ok = mode_ok && clk_ok; // [R24]
        clk_cfg.use_lf = (ctrl_r.clk_sel == CLK_SEL_SLOW) && (PRESCALER_TAP_SEL || SLEEP_MODE);
        clk_cfg.exp = clk_cfg.use_lf ? LF_EXP
            : (ctrl_r.clk_sel == CLK_SEL_SLOW) ? HF_EXP_SLOW
            : HF_EXP_FAST - 4'(ctrl_r.clk_sel);
        if (PRESCALER_BASE_SEL && !clk_cfg.use_lf) begin
            clk_cfg.exp = clk_cfg.exp + 4'd1;
        end
        last_bit = four ? 4'd3 : 4'd7;
        gap_mul = 3'((4'd1 << bctl_r.gap) - 4'd1);
        gap_len = {4'b0, gap_mul} * (four ? 7'd8 : 7'd16); // [R10]
    end

    ssc_tick_gen #(
        .CNT_W(DIV_W)
    ) u_tick (
        .clk(CLK),
        .nrst(NRST),
        .ce(CE),
        .run((state_r != ST_IDLE) && !ext),
        .sel(clk_cfg),
        .lf_tick(LF_TICK),
        .tick(tick)
    );

    // bus decode; one wait state, effect at the edge that sees PREADY high
    always_comb begin
        acc = PSEL && PENABLE && !pready_r;
        wr_fire = PSEL && PENABLE && PWRITE && pready_r;
        a_prim = (PADDR == ADDR_CTRL_PRIMARY);
        a_bctl = (PADDR == ADDR_CTRL_BUFFER);
        a_buf = (PADDR[15:5] == ADDR_BUF_BASE[15:5]) && (PADDR[1:0] == 2'b00);
        wr_prim = wr_fire && a_prim;
        wr_bctl = wr_fire && a_bctl; // [R23]
        pready_nxt = acc;
        pslverr_nxt = acc && !(a_prim || a_bctl || a_buf);
        prdata_nxt = prdata_r;
        if (acc) begin
            prdata_nxt = '0; // [R07]
            if (!PWRITE && a_bctl) begin
                prdata_nxt[STAT_ACTIVE_BIT] = (state_r != ST_IDLE); // [R17] [R23]
                prdata_nxt[STAT_SHIFT_BIT] = (state_r == ST_SHIFT); // [R18]
            end else if (!PWRITE && a_buf) begin
                prdata_nxt[7:0] = data_buffer_ram[PADDR[4:2]];
            end
        end
    end

    // shift engine
    always_comb begin
        fall_evt = ext ? (pin_q && !SERIAL_CLOCK_PIN_I) : (tick && sck_r);
        rise_evt = ext ? (!pin_q && SERIAL_CLOCK_PIN_I) : (tick && !sck_r);
        shifted = {SERIAL_IN_PIN, shreg_r[7:1]};
        rx_word = four ? {4'h0, shifted[7:4]} : shifted; // [R13]
        nidx = (widx_r == bctl_r.wcnt) ? 3'd0 : widx_r + 3'd1; // [R12]
        word_done = (state_r == ST_SHIFT) && rise_evt && (bitcnt_r == last_bit);
        start = (state_r == ST_IDLE) && ctrl_r.run && !ctrl_r.abort && cfg_ok;
        ctrl_nxt = ctrl_r;
        bctl_nxt = bctl_r; // [R15]
        state_nxt = state_r;
        shreg_nxt = shreg_r;
        bitcnt_nxt = bitcnt_r;
        widx_nxt = widx_r;
        gapcnt_nxt = gapcnt_r;
        sck_nxt = sck_r;
        so_nxt = so_r;
        irq_nxt = 1'b0;
        oe_nxt = !ext;
        buf_we = 1'b0;
        buf_wa = widx_r;
        buf_wd = rx_word;
        if (ctrl_r.abort) begin
            ctrl_nxt.abort = 1'b0; // [R02]
        end
        if (wr_prim) begin
            ctrl_nxt = ssc_ctrl_t'(PWDATA[7:0]);
        end
        if (wr_bctl) begin
            bctl_nxt = ssc_bufctl_t'(PWDATA[4:0]);
        end
        if (wr_fire && a_buf) begin
            buf_we = 1'b1;
            buf_wa = PADDR[4:2];
            buf_wd = PWDATA[7:0];
        end
        case (state_r)
            ST_IDLE: begin
                sck_nxt = 1'b1;
                if (start) begin // [R01]
                    state_nxt = ST_SHIFT;
                    widx_nxt = '0; // [R14]
                    bitcnt_nxt = '0;
                    shreg_nxt = data_buffer_ram[0];
                end
            end
            ST_SHIFT: begin
                if (!ext && tick) begin
                    sck_nxt = !sck_r;
                end
                if (fall_evt && tx_mode) begin
                    so_nxt = {7'b0, shreg_r[0]}; // [R20] [R21]
                end
                if (rise_evt) begin
                    shreg_nxt = shifted; // [R20]
                    bitcnt_nxt = bitcnt_r + 4'd1;
                end
                if (word_done) begin
                    if (rx_mode) begin
                        buf_we = 1'b1;
                        buf_wa = widx_r;
                        buf_wd = rx_word; // [R14]
                    end
                    irq_nxt = (widx_r == bctl_r.wcnt); // [R22]
                    widx_nxt = nidx;
                    bitcnt_nxt = '0;
                    shreg_nxt = (rx_mode && nidx == widx_r) ? rx_word : data_buffer_ram[nidx];
                    if (!ctrl_r.run) begin
                        state_nxt = ST_IDLE; // [R19]
                    end else if (gap_len != 7'd0 && !ext) begin
                        state_nxt = ST_GAP;
                        gapcnt_nxt = gap_len - 7'd1;
                    end
                end
            end
            ST_GAP: begin
                sck_nxt = 1'b1;
                shreg_nxt = data_buffer_ram[widx_r];
                if (!ctrl_r.run) begin
                    state_nxt = ST_IDLE;
                end else if (tick) begin
                    if (gapcnt_r == 7'd0) begin
                        state_nxt = ST_SHIFT; // [R10]
                    end else begin
                        gapcnt_nxt = gapcnt_r - 7'd1;
                    end
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
        if (state_r != ST_IDLE && (ctrl_r.abort || !cfg_ok)) begin
            state_nxt = ST_IDLE; // [R19] [R24]
            sck_nxt = 1'b1;
        end
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            ctrl_r <= ssc_ctrl_t'(PRIMARY_RST); // [R08]
            bctl_r <= ssc_bufctl_t'(BUFCTL_RST); // [R09]
            state_r <= ST_IDLE;
            shreg_r <= '0;
            bitcnt_r <= '0;
            widx_r <= '0;
            gapcnt_r <= '0;
            sck_r <= 1'b1;
            so_r <= SO_IDLE;
            oe_r <= 1'b1;
            irq_r <= 1'b0;
            pin_q <= 1'b1;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= '0;
        end else if (CE) begin
            ctrl_r <= ctrl_nxt;
            bctl_r <= bctl_nxt;
            state_r <= state_nxt;
            shreg_r <= shreg_nxt;
            bitcnt_r <= bitcnt_nxt;
            widx_r <= widx_nxt;
            gapcnt_r <= gapcnt_nxt;
            sck_r <= sck_nxt;
            so_r <= so_nxt;
            oe_r <= oe_nxt;
            irq_r <= irq_nxt;
            pin_q <= SERIAL_CLOCK_PIN_I;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            prdata_r <= prdata_nxt;
        end
    end

    // buffer contents are data, so no reset; engine store wins over bus write
    always_ff @(posedge CLK) begin
        if (CE && buf_we) begin
            data_buffer_ram[buf_wa] <= buf_wd;
        end
    end

    assign PRDATA = prdata_r;
    assign PREADY = pready_r;
    assign PSLVERR = pslverr_r;
    assign SERIAL_CLOCK_PIN_O = sck_r;
    assign SERIAL_CLOCK_PIN_OE = oe_r;
    assign SERIAL_OUT_PIN = so_r[0];
    assign SERIAL_DONE_IRQ = irq_r;

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!NRST);

    abort_self_clear_a: assert property (CE && ctrl_r.abort && !wr_prim |=> !ctrl_r.abort) // [R02]
        else $error("abort bit did not clear itself");
    abort_stops_a: assert property (CE && ctrl_r.abort |=> state_r == ST_IDLE) // [R19]
        else $error("abort did not end transfer at once");
    stop_no_start_a: assert property (CE && state_r == ST_IDLE && !ctrl_r.run // [R01]
        |=> state_r == ST_IDLE)
        else $error("transfer started with run clear");
    rsvd_no_start_a: assert property (CE && !cfg_ok |=> state_r == ST_IDLE) // [R24]
        else $error("reserved code ran the port");
    status_active_a: assert property (CE && acc && !PWRITE && a_bctl // [R17]
        |=> PRDATA[STAT_ACTIVE_BIT] == ($past(state_r) != ST_IDLE))
        else $error("status active bit wrong");
    status_shift_a: assert property (CE && acc && !PWRITE && a_bctl // [R18]
        |=> PRDATA[STAT_SHIFT_BIT] == ($past(state_r) == ST_SHIFT))
        else $error("status shift bit wrong");
    nibble_upper_zero_a: assert property (buf_we && four && !(wr_fire && a_buf) // [R13]
        |-> buf_wd[7:4] == 4'h0)
        else $error("upper nibble not zero on receive");
    lsb_first_a: assert property (CE && state_r == ST_SHIFT && fall_evt && tx_mode // [R21]
        && !ctrl_r.abort && cfg_ok |=> SERIAL_OUT_PIN == $past(shreg_r[0]))
        else $error("serial out not the low bit");
    burst_done_a: assert property (CE && word_done && widx_r == bctl_r.wcnt // [R22]
        |=> SERIAL_DONE_IRQ ##1 !SERIAL_DONE_IRQ || !CE)
        else $error("done pulse missing");
    first_word_a: assert property (CE && start |=> widx_r == 3'd0 && bitcnt_r == 4'd0) // [R14]
        else $error("burst did not begin at buffer base");

    start_seen_c: cover property (CE && start);
    burst_done_c: cover property (SERIAL_DONE_IRQ);
    gap_seen_c: cover property (state_r == ST_GAP);
    abort_seen_c: cover property (ctrl_r.abort && state_r == ST_SHIFT);
endmodule // ssc_serial_port

// ### verif/ssc_peer.sv
// far-side serial peripheral: shifts tx_bits out, records what the port sends
module ssc_peer (
    // serial pins
    input wire logic sck,
    input wire logic so,
    output logic si,
    // bench control
    input wire logic clr,
    input wire logic [31:0] tx_bits,
    output logic [63:0] rx_bits,
    output int n_bits
);
    timeunit 1ns;
    timeprecision 1ns;
    int tx_idx;
    initial si = 1'b0;
    // data change on the falling pin edge, so it is settled at the rise
    always @(negedge sck or posedge clr) begin
        if (clr) begin
            tx_idx <= 0;
            si <= ~si;
        end else begin
            si <= tx_bits[tx_idx[4:0]];
            tx_idx <= tx_idx + 1;
        end
    end
    always @(posedge sck or posedge clr) begin
        if (clr) begin
            n_bits <= 0;
        end else begin
            rx_bits[n_bits[5:0]] <= so;
            n_bits <= n_bits + 1;
        end
    end
endmodule // ssc_peer

// ### verif/test_sync_serial_control_status.sv
module test_sync_serial_control_status import ssc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    // 8-bit word time at clock code 101: sixteen half periods of 2^(exp-1) cycles
    localparam int WORD_CYC = 16 << (HF_EXP_FAST - 6);
    logic clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, sleep_mode = 0, lf_tick = 0;
    logic ext_sck = 1, tap_sel = 0, base_sel = 0;
    logic [15:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd, tx_bits = '0;
    logic pready, pslverr, sck_o, sck_oe, so, si, irq, err, clr = 1;
    logic [63:0] rx_bits;
    logic [7:0] b [3];
    logic [7:0] exp_q [$];
    logic [7:0] cfg [11] = '{8'h85, 8'h95, 8'ha5, 8'had, 8'hb5,
                             8'h8d, 8'h9d, 8'hbd, 8'h86, 8'h85, 8'h80};
    int n_bits, n_fail = 0, checks = 0, seed = 12, n_irq = 0, irq0 = 0, cyc = 0;
    // released pin follows the bench's clock source, which idles high like a pull-up
    wire logic sck = sck_oe ? sck_o : ext_sck;

    ssc_serial_port DUT (.CLK(clk), .NRST(nrst), .CE(1'b1), .PADDR(paddr), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .PRESCALER_TAP_SEL(tap_sel),
        .PRESCALER_BASE_SEL(base_sel), .SLEEP_MODE(sleep_mode), .LF_TICK(lf_tick),
        .SERIAL_CLOCK_PIN_I(sck), .SERIAL_CLOCK_PIN_O(sck_o), .SERIAL_CLOCK_PIN_OE(sck_oe),
        .SERIAL_OUT_PIN(so), .SERIAL_IN_PIN(si), .SERIAL_DONE_IRQ(irq));
    ssc_peer peer (.sck(sck), .so(so), .si(si), .clr(clr), .tx_bits(tx_bits),
        .rx_bits(rx_bits), .n_bits(n_bits));

    initial forever #2 clk = ~clk;
    always @(posedge clk) lf_tick <= ($random(seed) & 15) == 0;
    always @(posedge clk) if (irq === 1'b1) n_irq <= n_irq + 1;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] wd);
        @(posedge clk);
        psel <= 1;
        penable <= 0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask

    task automatic wait_irq;
        for (int i = 0; i < 4000 && irq !== 1'b1; i++) @(posedge clk);
    endtask

    task automatic wait_idle;
        rd = 32'h80;
        for (int i = 0; i < 200 && rd[7] !== 1'b0; i++) apb(0, ADDR_STATUS, 0);
    endtask

    task automatic test_done;
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        #200000;
        n_fail++;
        test_done();
    end

    initial begin
        repeat (20) @(posedge clk);
        nrst <= 1;
        clr <= 0;
        apb(0, ADDR_STATUS, 0);
        chk(rd, 0);
        apb(0, ADDR_CTRL_PRIMARY, 0);
        chk(rd, 0);
        apb(1, 16'h0000, 32'h5a);
        chk({31'h0, err}, 1);
        $display("test reset done");
        for (int k = 0; k < 3; k++) b[k] = $random(seed);
        apb(1, ADDR_BUF_BASE, {24'h0, b[0]});
        apb(1, ADDR_BUF_BASE + 16'h4, {24'h0, b[1]});
        apb(1, ADDR_CTRL_PRIMARY, 8'h45);
        apb(1, ADDR_CTRL_BUFFER, 8'h01);
        apb(1, ADDR_CTRL_PRIMARY, 8'h85);
        apb(0, ADDR_STATUS, 0);
        chk({31'h0, rd[7]}, 1);
        wait_irq();
        chk(n_bits, 16);
        apb(1, ADDR_CTRL_PRIMARY, 8'h05);
        wait_idle();
        exp_q = {b[0], b[1], b[0]};
        chk(n_bits, 24);
        for (int k = 0; k < 3; k++) chk(rx_bits[8*k +: 8], exp_q[k]);
        $display("test tx8 done");
        clr <= 1;
        @(posedge clk);
        clr <= 0;
        apb(1, ADDR_CTRL_PRIMARY, 8'h85);
        wait_irq();
        chk(n_bits, 16);
        apb(1, ADDR_CTRL_PRIMARY, 8'h45);
        apb(0, ADDR_STATUS, 0);
        chk(rd, 0);
        $display("test abort done");
        tx_bits = $random(seed);
        clr <= 1;
        @(posedge clk);
        clr <= 0;
        apb(1, ADDR_CTRL_PRIMARY, 8'h75);
        apb(1, ADDR_CTRL_BUFFER, 8'h02);
        apb(1, ADDR_CTRL_PRIMARY, 8'hb5);
        wait_irq();
        apb(1, ADDR_CTRL_PRIMARY, 8'h75);
        chk(n_bits, 12);
        for (int k = 0; k < 3; k++) begin
            apb(0, ADDR_BUF_BASE + 16'(4 * k), 0);
            chk(rd, {28'h0, tx_bits[4*k +: 4]});
        end
        $display("test rx4 done");
        // tx/rx 8-bit, two words, one word time of wait per frame
        clr <= 1;
        @(posedge clk);
        clr <= 0;
        apb(1, ADDR_CTRL_PRIMARY, 8'h65);
        apb(1, ADDR_CTRL_BUFFER, 8'h09);
        apb(1, ADDR_CTRL_PRIMARY, 8'ha5);
        cyc = 0;
        while (irq !== 1'b1 && cyc < 4000) begin
            @(posedge clk);
            cyc++;
        end
        apb(1, ADDR_CTRL_PRIMARY, 8'h65);
        chk(cyc & ~7, 3 * WORD_CYC);
        chk(n_bits, 16);
        chk(rx_bits[15:0], {4'h0, tx_bits[7:4], 4'h0, tx_bits[3:0]});
        apb(0, ADDR_BUF_BASE, 0);
        chk(rd, {24'h0, tx_bits[7:0]});
        $display("test gap done");
        // external clock: the port releases the pin and the bench clocks it
        clr <= 1;
        @(posedge clk);
        clr <= 0;
        apb(1, ADDR_CTRL_BUFFER, 8'h00);
        apb(1, ADDR_CTRL_PRIMARY, 8'h47);
        apb(1, ADDR_CTRL_PRIMARY, 8'h87);
        irq0 = n_irq;
        for (int k = 0; k < 16; k++) begin
            repeat (8) @(posedge clk);
            ext_sck <= k[0];
        end
        repeat (8) @(posedge clk);
        chk({31'h0, sck_oe}, 0);
        chk(n_irq - irq0, 1);
        chk(n_bits, 8);
        chk(rx_bits[7:0], tx_bits[7:0]);
        apb(1, ADDR_CTRL_PRIMARY, 8'h47);
        apb(0, ADDR_STATUS, 0);
        chk(rd, 0);
        $display("test ext done");
        for (int k = 0; k < 11; k++) begin
            sleep_mode <= (k >= 9);
            {tap_sel, base_sel} <= 2'($random(seed));
            apb(1, ADDR_CTRL_PRIMARY, {24'h0, cfg[k] ^ 8'hc0});
            apb(1, ADDR_CTRL_PRIMARY, {24'h0, cfg[k]});
            apb(0, ADDR_STATUS, 0);
            chk({31'h0, rd[7]}, {31'h0, k < 5 || k == 10});
            apb(1, ADDR_CTRL_PRIMARY, {24'h0, cfg[k] ^ 8'hc0});
        end
        $display("test modes done");
        test_done();
    end
endmodule // test_sync_serial_control_status
